// [hdl/tap_axis_compare.sv]
module tap_axis_compare import tap_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	tap_cmp_if.cmp bus
);
	logic [2:0][SAMPLE_W-1:0] prev;
	logic [2:0] next_hit;
	logic [2:0] next_neg;
	logic take;

	// Improved mode runs on output-rate data, else undecimated data
	assign take = bus.improved ? bus.filt_stb : bus.raw_stb;

	generate
		for (genvar a = 0; a < 3; a++) begin : g_axis
			logic signed [SAMPLE_W:0] val;
			logic [SAMPLE_W:0] mag;
			// Ac-coupled difference of successive filtered samples
			assign val = bus.improved ?
				($signed({bus.filt[a][SAMPLE_W-1], bus.filt[a]}) -
				$signed({prev[a][SAMPLE_W-1], prev[a]})) :
				$signed({bus.raw[a][SAMPLE_W-1], bus.raw[a]});
			assign mag = val[SAMPLE_W] ? (SAMPLE_W+1)'(-val) : val;
			assign next_hit[a] = bus.axis_en[a] &&
				(mag > {{(SAMPLE_W+1-8-LEVEL_SHIFT){1'b0}}, bus.level,
				{LEVEL_SHIFT{1'b0}}});
			assign next_neg[a] = val[SAMPLE_W];

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					prev[a] <= '0;
				end else if (bus.filt_stb) begin
					prev[a] <= bus.filt[a];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bus.hit <= 3'h0;
			bus.neg <= 3'h0;
			bus.above <= 1'b0;
		end else if (take) begin
			bus.hit <= next_hit;
			bus.neg <= next_neg;
			bus.above <= |next_hit;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bus.stb <= 1'b0;
		end else begin
			bus.stb <= take;
		end
	end
endmodule : tap_axis_compare

// [hdl/tap_cmp_if.sv]
interface tap_cmp_if;
	import tap_pkg::*;
	logic [2:0][SAMPLE_W-1:0] raw;
	logic [2:0][SAMPLE_W-1:0] filt;
	logic raw_stb;
	logic filt_stb;
	logic improved;
	logic [7:0] level;
	logic [2:0] axis_en;
	logic stb;
	logic above;
	logic [2:0] hit;
	logic [2:0] neg;
	modport cmp (input raw, filt, raw_stb, filt_stb, improved, level,
		axis_en, output stb, above, hit, neg);
	modport ctl (output raw, filt, raw_stb, filt_stb, improved, level,
		axis_en, input stb, above, hit, neg);
endinterface : tap_cmp_if

// [hdl/tap_event_detector.sv]
// Notes on behaviour
// - An axis taps only while its magnitude exceeds the tap level limit.
// - An excursion lasting past the length limit is not a tap.
// - After the first tap ends, wait the gap time before the interval.
// - Second tap must start inside the interval, may end after it.
// - Single only: single flag when acceleration falls below the level.
// - Both enabled: single flag waits until the double tap is judged.
// - Suppress bit: any excursion during the gap cancels the double tap.
// - Above level when the interval opens rejects the double tap.
// - Second excursion past the length limit rejects the double tap.
// - Single and double detection have their own enable bits.
// - Each axis joins only when its axis control bit is set.
// - First axis of a tap is recorded, never cleared, only overwritten.
// - Improved mode uses ac-coupled filtered data at the output rate.
// - Negative acceleration reports a negative sign for that axis.
// - Normal mode uses undecimated samples at the internal rate.
// - Sign one means negative; updates on new taps, enabled axes only.
module tap_event_detector import tap_pkg::*; #(
	parameter int TICK_CYCLES = LENGTH_UNIT_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic raw_stb,
	input wire logic [SAMPLE_W-1:0] raw_x,
	input wire logic [SAMPLE_W-1:0] raw_y,
	input wire logic [SAMPLE_W-1:0] raw_z,
	input wire logic filt_stb,
	input wire logic [SAMPLE_W-1:0] filt_x,
	input wire logic [SAMPLE_W-1:0] filt_y,
	input wire logic [SAMPLE_W-1:0] filt_z,
	output logic [3:0] rate_code,
	output logic single_tap,
	output logic double_tap
);
	tap_cmp_if cmp ();
	tap_state_e state;
	logic [7:0] tap_level_limit;
	logic [7:0] tap_length_limit;
	logic [7:0] tap_gap_time;
	logic [7:0] second_tap_interval;
	logic [7:0] tap_axis_control;
	logic [7:0] motion_event_status;
	logic [7:0] output_rate_control;
	logic [7:0] irq_enable_mask;
	logic [7:0] irq_source_flags;
	logic [2:0] tap_sign;
	logic [2:0] first_hit;
	logic [2:0] first_neg;
	logic [7:0] len_cnt;
	logic [7:0] gap_cnt;
	logic [7:0] win_cnt;
	logic tick_fast;
	logic tick_slow;
	logic st_en;
	logic dt_en;
	logic dt_ok;
	logic rise;
	logic tap_end;
	logic len_over;
	logic veto;
	logic gap_done;
	logic win_done;
	logic set_single;
	logic set_double;
	logic rd_src;

	tap_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_timebase (
		.clk(clk),
		.reset_n(reset_n),
		.tick_fast(tick_fast),
		.tick_slow(tick_slow)
	);

	tap_axis_compare u_compare (
		.clk(clk),
		.reset_n(reset_n),
		.bus(cmp.cmp)
	);

	assign cmp.raw = {raw_z, raw_y, raw_x};
	assign cmp.filt = {filt_z, filt_y, filt_x};
	assign cmp.raw_stb = raw_stb;
	assign cmp.filt_stb = filt_stb;
	assign cmp.improved = tap_axis_control[BIT_IMPROVED];
	assign cmp.level = tap_level_limit;
	assign cmp.axis_en = tap_axis_control[2:0];

	assign st_en = irq_enable_mask[BIT_SINGLE];
	assign dt_en = irq_enable_mask[BIT_DOUBLE];
	// Zero gap or interval would open a window that never exists
	assign dt_ok = dt_en && (tap_gap_time != 8'h00) &&
		(second_tap_interval != 8'h00);
	assign rise = cmp.stb && cmp.above;
	assign tap_end = cmp.stb && !cmp.above;
	assign len_over = tick_fast && (len_cnt == tap_length_limit);
	assign veto = tap_axis_control[BIT_SUPPRESS] && rise;
	assign gap_done = tick_slow && (gap_cnt == tap_gap_time - 8'h01);
	assign win_done = tick_slow &&
		(win_cnt == second_tap_interval - 8'h01);

	// Single flag is held back until the double tap is decided
	always_comb begin
		set_single = 1'b0;
		set_double = 1'b0;
		unique case (state)
			ST_FIRST: set_single = st_en && tap_end && !len_over && !dt_ok;
			ST_GAP: set_single = st_en &&
				(veto || (gap_done && cmp.above));
			ST_INTERVAL: set_single = st_en && win_done && !rise;
			ST_SECOND: begin
				set_single = st_en && (tap_end || len_over);
				set_double = tap_end && !len_over;
			end
			ST_IDLE, ST_WAIT_LOW: ;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: if (rise && (st_en || dt_en)) begin
					state <= ST_FIRST;
				end
				ST_FIRST: if (len_over) begin
					state <= ST_WAIT_LOW;
				end else if (tap_end) begin
					state <= dt_ok ? ST_GAP : ST_IDLE;
				end
				ST_GAP: if (veto) begin
					state <= ST_WAIT_LOW;
				end else if (gap_done) begin
					state <= cmp.above ? ST_WAIT_LOW : ST_INTERVAL;
				end
				ST_INTERVAL: if (rise) begin
					state <= ST_SECOND;
				end else if (win_done) begin
					state <= ST_IDLE;
				end
				ST_SECOND: if (len_over) begin
					state <= ST_WAIT_LOW;
				end else if (tap_end) begin
					state <= ST_IDLE;
				end
				ST_WAIT_LOW: if (tap_end) begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Length counts in every state but idle and the interval, which clear it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			len_cnt <= 8'h00;
		end else if (state == ST_IDLE || state == ST_INTERVAL) begin
			len_cnt <= 8'h00;
		end else if (tick_fast && len_cnt != 8'hff) begin
			len_cnt <= len_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gap_cnt <= 8'h00;
		end else if (state != ST_GAP) begin
			gap_cnt <= 8'h00;
		end else if (tick_slow) begin
			gap_cnt <= gap_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			win_cnt <= 8'h00;
		end else if (state != ST_INTERVAL) begin
			win_cnt <= 8'h00;
		end else if (tick_slow) begin
			win_cnt <= win_cnt + 8'h01;
		end
	end

	// First axes over the level are caught when the first tap starts
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			first_hit <= 3'h0;
			first_neg <= 3'h0;
		end else if (state == ST_IDLE && rise) begin
			first_hit <= cmp.hit;
			first_neg <= cmp.neg;
		end
	end

	// Record is overwritten by each new tap, never cleared
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			motion_event_status <= REG_RESET;
		end else if (set_single || set_double) begin
			motion_event_status[2:0] <= first_hit;
		end
	end

	generate
		for (genvar a = 0; a < 3; a++) begin : g_sign
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					tap_sign[a] <= 1'b0;
				end else if ((set_single || set_double) &&
					tap_axis_control[a]) begin
					tap_sign[a] <= first_neg[a];
				end
			end
		end
	endgenerate

	assign rd_src = reg_rd && (reg_addr == ADDR_IRQ_SRC);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tap_level_limit <= REG_RESET;
			tap_length_limit <= REG_RESET;
			tap_gap_time <= REG_RESET;
			second_tap_interval <= REG_RESET;
			tap_axis_control <= REG_RESET;
			output_rate_control <= RATE_RESET;
			irq_enable_mask <= REG_RESET;
		end else if (reg_wr) begin
			unique case (reg_addr)
				ADDR_LEVEL: tap_level_limit <= reg_wdata;
				ADDR_LENGTH: tap_length_limit <= reg_wdata;
				ADDR_GAP: tap_gap_time <= reg_wdata;
				ADDR_INTERVAL: second_tap_interval <= reg_wdata;
				ADDR_AXIS_CTL: tap_axis_control <= reg_wdata;
				ADDR_RATE: output_rate_control <= reg_wdata;
				ADDR_IRQ_EN: irq_enable_mask <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Reading the source clears it; a tap in the same cycle survives
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_source_flags <= REG_RESET;
		end else begin
			if (rd_src) begin
				irq_source_flags <= REG_RESET;
			end
			if (set_single) begin
				irq_source_flags[BIT_SINGLE] <= 1'b1;
			end
			if (set_double) begin
				irq_source_flags[BIT_DOUBLE] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_LEVEL: reg_rdata <= tap_level_limit;
				ADDR_LENGTH: reg_rdata <= tap_length_limit;
				ADDR_GAP: reg_rdata <= tap_gap_time;
				ADDR_INTERVAL: reg_rdata <= second_tap_interval;
				ADDR_AXIS_CTL: reg_rdata <= tap_axis_control;
				ADDR_STATUS: reg_rdata <= motion_event_status;
				ADDR_RATE: reg_rdata <= output_rate_control;
				ADDR_IRQ_EN: reg_rdata <= irq_enable_mask;
				ADDR_IRQ_SRC: reg_rdata <= irq_source_flags;
				ADDR_SIGN: reg_rdata <= {1'b0, tap_sign[0], tap_sign[1],
					tap_sign[2], 1'b0, motion_event_status[2:0]};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	assign rate_code = output_rate_control[3:0];
	assign single_tap = irq_source_flags[BIT_SINGLE];
	assign double_tap = irq_source_flags[BIT_DOUBLE];

	property p_start;
		@(posedge clk) disable iff (!reset_n)
		(state == ST_IDLE && rise && st_en) |=> (state == ST_FIRST);
	endproperty
	a_start: assert property (p_start)
		else $error("tap start missed");

	property p_length;
		@(posedge clk) disable iff (!reset_n)
		(state == ST_FIRST && len_over) |=> (state == ST_WAIT_LOW) &&
		!$rose(irq_source_flags[BIT_SINGLE]);
	endproperty
	a_length: assert property (p_length)
		else $error("overlong tap accepted");

	property p_single;
		@(posedge clk) disable iff (!reset_n)
		(state == ST_FIRST && tap_end && !len_over && st_en && !dt_ok)
		|=> irq_source_flags[BIT_SINGLE] && state == ST_IDLE;
	endproperty
	a_single: assert property (p_single)
		else $error("single flag not raised");

	property p_defer;
		@(posedge clk) disable iff (!reset_n)
		(state == ST_INTERVAL && !win_done) |=>
		!$rose(irq_source_flags[BIT_SINGLE]);
	endproperty
	a_defer: assert property (p_defer)
		else $error("single flag not deferred");

	property p_veto;
		@(posedge clk) disable iff (!reset_n)
		(state == ST_GAP && veto) |=> state == ST_WAIT_LOW && !set_double;
	endproperty
	a_veto: assert property (p_veto)
		else $error("spike in gap did not cancel");

	property p_open_high;
		@(posedge clk) disable iff (!reset_n)
		(state == ST_GAP && !veto && gap_done && cmp.above)
		|=> state == ST_WAIT_LOW;
	endproperty
	a_open_high: assert property (p_open_high)
		else $error("double tap not rejected at open");

	property p_second_long;
		@(posedge clk) disable iff (!reset_n)
		(state == ST_SECOND && len_over) |-> !set_double
		##1 (state == ST_WAIT_LOW);
	endproperty
	a_second_long: assert property (p_second_long)
		else $error("long second tap accepted");

	property p_enable;
		@(posedge clk) disable iff (!reset_n)
		(!dt_en && state == ST_FIRST) |=> state != ST_GAP;
	endproperty
	a_enable: assert property (p_enable)
		else $error("double path without enable");

	property p_record;
		@(posedge clk) disable iff (!reset_n)
		(set_single || set_double) |=>
		motion_event_status[2:0] == $past(first_hit);
	endproperty
	a_record: assert property (p_record)
		else $error("first axis not recorded");

	property p_both;
		@(posedge clk) disable iff (!reset_n)
		(set_double && st_en) |=>
		irq_source_flags[BIT_SINGLE] && irq_source_flags[BIT_DOUBLE];
	endproperty
	a_both: assert property (p_both)
		else $error("flags not raised together");
endmodule : tap_event_detector

// [hdl/tap_pkg.sv]
package tap_pkg;
	// Register addresses on the serial host port
	localparam logic [5:0] ADDR_LEVEL = 6'h1d;
	localparam logic [5:0] ADDR_LENGTH = 6'h21;
	localparam logic [5:0] ADDR_GAP = 6'h22;
	localparam logic [5:0] ADDR_INTERVAL = 6'h23;
	localparam logic [5:0] ADDR_AXIS_CTL = 6'h2a;
	localparam logic [5:0] ADDR_STATUS = 6'h2b;
	localparam logic [5:0] ADDR_RATE = 6'h2c;
	localparam logic [5:0] ADDR_IRQ_EN = 6'h2e;
	localparam logic [5:0] ADDR_IRQ_SRC = 6'h30;
	localparam logic [5:0] ADDR_SIGN = 6'h3a;
	// Field positions
	localparam int BIT_SINGLE = 6;
	localparam int BIT_DOUBLE = 5;
	localparam int BIT_IMPROVED = 4;
	localparam int BIT_SUPPRESS = 3;
	localparam int SIGN_LSB = 4;
	// Reset values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h0a;
	// Threshold lsb is sixteen data lsbs
	localparam int LEVEL_SHIFT = 4;
	// Timing: length unit 625 us, gap and interval unit 1.25 ms
	localparam int CLK_PERIOD_NS = 40;
	localparam int LENGTH_UNIT_NS = 625000;
	localparam int LENGTH_UNIT_CYCLES = LENGTH_UNIT_NS / CLK_PERIOD_NS;
	localparam int SLOW_PER_FAST = 2;
	localparam int SAMPLE_W = 13;
	typedef enum logic [2:0] {
		ST_IDLE, ST_FIRST, ST_GAP, ST_INTERVAL, ST_SECOND, ST_WAIT_LOW
	} tap_state_e;
endpackage : tap_pkg

// [hdl/tap_timebase.sv]
module tap_timebase import tap_pkg::*; #(
	parameter int TICK_CYCLES = LENGTH_UNIT_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	output logic tick_fast,
	output logic tick_slow
);
	localparam int CW = $clog2(TICK_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
	logic [CW-1:0] count;
	logic half;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
		end else if (count == LAST) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	// Slow tick is every second fast tick
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			half <= 1'b0;
		end else if (count == LAST) begin
			half <= ~half;
		end
	end

	assign tick_fast = (count == LAST);
	assign tick_slow = (count == LAST) && half;
endmodule : tap_timebase

// [verif/host_model.sv]
module host_model (
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output logic [5:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_addr = 6'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Single bytes only, changed off the sampling edge
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		// Stale data would hide a late capture
		reg_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd
endmodule : host_model

// [verif/tb.sv]
module tb import tap_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 10;
	localparam logic [SAMPLE_W-1:0] HI = 13'h00c8;
	localparam logic [SAMPLE_W-1:0] NEG = 13'h1f38;
	localparam logic [SAMPLE_W-1:0] EQ = 13'h0040;
	logic clk;
	logic reset_n;
	logic raw_stb;
	logic filt_stb;
	logic [SAMPLE_W-1:0] raw_x, raw_y, raw_z, filt_x, filt_y, filt_z;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rd_val;
	logic reg_wr, reg_rd, single_tap, double_tap;
	logic [3:0] rate_code;
	int errors;
	int checks;
	logic [5:0] zero_regs [9] = '{ADDR_LEVEL, ADDR_LENGTH, ADDR_GAP,
		ADDR_INTERVAL, ADDR_AXIS_CTL, ADDR_STATUS, ADDR_IRQ_EN, ADDR_IRQ_SRC,
		6'h3f};

	tap_event_detector #(.TICK_CYCLES(TICK)) u_dut (.clk(clk),
		.reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.raw_stb(raw_stb), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
		.filt_stb(filt_stb), .filt_x(filt_x), .filt_y(filt_y),
		.filt_z(filt_z), .rate_code(rate_code), .single_tap(single_tap),
		.double_tap(double_tap));
	host_model u_host (.clk(clk), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic final_report;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string name, input logic [7:0] exp, got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic rd_chk(input string name, input logic [5:0] a,
		input logic [7:0] exp);
		u_host.rd(a, rd_val);
		chk(name, exp, rd_val);
	endtask : rd_chk

	// One strobe every other cycle; values hold between strobes
	task automatic samp(input logic f, input logic [SAMPLE_W-1:0] x, y, z,
		input int n);
		repeat (n) begin
			@(negedge clk);
			if (f) begin
				{filt_x, filt_y, filt_z, filt_stb} = {x, y, z, 1'b1};
			end else begin
				{raw_x, raw_y, raw_z, raw_stb} = {x, y, z, 1'b1};
			end
			@(negedge clk);
			raw_stb = 1'b0;
			filt_stb = 1'b0;
		end
	endtask : samp

	// Quiet samples until a flag rises, bounded; then read and clear
	task automatic expect_flags(input string name, input logic [7:0] exp);
		int i;
		i = 0;
		while (single_tap !== 1'b1 && double_tap !== 1'b1 && i < 300) begin
			samp(1'b0, 13'h0000, 13'h0000, 13'h0000, 1);
			i++;
		end
		chk({name, " double"}, {7'h00, exp[BIT_DOUBLE]}, {7'h00, double_tap});
		rd_chk(name, ADDR_IRQ_SRC, exp);
		$display("test %s done", name);
	endtask : expect_flags

	// Quiet first ends a held excursion, so each pair starts from idle
	task automatic dtap(input logic sp, input int g, l);
		samp(1'b0, 13'h0000, 13'h0000, 13'h0000, 2);
		samp(1'b0, HI, 13'h0000, 13'h0000, 5);
		samp(1'b0, 13'h0000, 13'h0000, 13'h0000, 2);
		chk("single held", 8'h00, {7'h00, single_tap});
		if (sp) begin
			samp(1'b0, HI, 13'h0000, 13'h0000, 2);
		end
		samp(1'b0, 13'h0000, 13'h0000, 13'h0000, g);
		samp(1'b0, HI, 13'h0000, 13'h0000, l);
	endtask : dtap

	initial begin
		repeat (50000) @(posedge clk);
		errors++;
		final_report();
	end

	initial begin
		errors = 0;
		checks = 0;
		reset_n = 1'b0;
		{raw_stb, filt_stb} = 2'b00;
		{raw_x, raw_y, raw_z} = '0;
		{filt_x, filt_y, filt_z} = '0;
		repeat (20) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		foreach (zero_regs[i]) rd_chk("reset value", zero_regs[i], REG_RESET);
		rd_chk("rate reset", ADDR_RATE, RATE_RESET);
		chk("rate code", 8'h0a, {4'h0, rate_code});
		u_host.wr(ADDR_STATUS, 8'hff);
		rd_chk("status read only", ADDR_STATUS, 8'h00);
		u_host.wr(ADDR_LENGTH, 8'h11);
		u_host.wr(ADDR_GAP, 8'h11);
		u_host.wr(ADDR_INTERVAL, 8'h41);
		rd_chk("length", ADDR_LENGTH, 8'h11);
		rd_chk("gap", ADDR_GAP, 8'h11);
		rd_chk("interval", ADDR_INTERVAL, 8'h41);
		u_host.wr(ADDR_LEVEL, 8'h04);
		rd_chk("level", ADDR_LEVEL, 8'h04);
		u_host.wr(ADDR_LENGTH, 8'h04);
		u_host.wr(ADDR_IRQ_EN, 8'h40);
		u_host.wr(ADDR_AXIS_CTL, 8'h01);
		samp(1'b0, 13'h0000, HI, 13'h0000, 5);
		expect_flags("axis off", 8'h00);
		samp(1'b0, EQ, 13'h0000, 13'h0000, 5);
		expect_flags("equal level", 8'h00);
		samp(1'b0, NEG, 13'h0000, 13'h0000, 5);
		expect_flags("single", 8'h40);
		chk("flag cleared", 8'h00, {7'h00, single_tap});
		rd_chk("status", ADDR_STATUS, 8'h01);
		rd_chk("sign", ADDR_SIGN, 8'h41);
		samp(1'b0, HI, 13'h0000, 13'h0000, 30);
		expect_flags("too long", 8'h00);
		rd_chk("status kept", ADDR_STATUS, 8'h01);
		u_host.wr(ADDR_AXIS_CTL, 8'h02);
		samp(1'b0, NEG, HI, 13'h0000, 5);
		expect_flags("y only", 8'h40);
		rd_chk("sign y", ADDR_SIGN, 8'h42);
		u_host.wr(ADDR_AXIS_CTL, 8'h01);
		u_host.wr(ADDR_LENGTH, 8'h0a);
		u_host.wr(ADDR_GAP, 8'h03);
		u_host.wr(ADDR_INTERVAL, 8'h04);
		u_host.wr(ADDR_IRQ_EN, 8'h60);
		dtap(1'b0, 33, 5);
		expect_flags("double", 8'h60);
		dtap(1'b0, 43, 30);
		expect_flags("late finish", 8'h60);
		dtap(1'b0, 3, 3);
		expect_flags("in gap", 8'h40);
		dtap(1'b0, 8, 35);
		expect_flags("above at open", 8'h40);
		dtap(1'b0, 33, 60);
		expect_flags("long second", 8'h40);
		u_host.wr(ADDR_IRQ_EN, 8'h20);
		dtap(1'b0, 33, 5);
		expect_flags("double only", 8'h20);
		u_host.wr(ADDR_IRQ_EN, 8'h60);
		u_host.wr(ADDR_AXIS_CTL, 8'h09);
		dtap(1'b1, 31, 5);
		expect_flags("spike veto", 8'h40);
		// Improved mode: output period is two cycles, below every time unit
		u_host.wr(ADDR_IRQ_EN, 8'h40);
		u_host.wr(ADDR_AXIS_CTL, 8'h11);
		samp(1'b0, HI, 13'h0000, 13'h0000, 5);
		expect_flags("raw ignored", 8'h00);
		samp(1'b1, 13'h0000, 13'h0000, 13'h0000, 3);
		samp(1'b1, HI, 13'h0000, 13'h0000, 4);
		expect_flags("improved", 8'h40);
		rd_chk("sign positive", ADDR_SIGN, 8'h01);
		u_host.wr(ADDR_AXIS_CTL, 8'h01);
		samp(1'b1, HI, 13'h0000, 13'h0000, 4);
		expect_flags("filtered ignored", 8'h00);
		final_report();
	end
endmodule : tb
